// [shared/vm_pkg.sv]
/*
  Constants, field layouts and carrier types for the regulator voltage monitor.
  Assumes one monitor clock at CLK_HZ, with comparator trips already synchronous to it.
*/
package vm_pkg;
  localparam int NCH = 11;
  localparam int NSW = 7;
  localparam int NLIN = 4;
  localparam int CW = 14;
  localparam longint CLK_HZ = 100_000_000;

  // Trip levels in percent of nominal, indexed by the two-bit level code
  localparam int UV_PCT0 = 95;
  localparam int UV_PCT1 = 93;
  localparam int UV_PCT2 = 91;
  localparam int UV_PCT3 = 89;
  localparam int OV_PCT0 = 105;
  localparam int OV_PCT1 = 107;
  localparam int OV_PCT2 = 109;
  localparam int OV_PCT3 = 111;

  localparam int UV_DB0_US = 5;
  localparam int UV_DB1_US = 15;
  localparam int UV_DB2_US = 25;
  localparam int UV_DB3_US = 40;
  localparam int OV_DB0_US = 25;
  localparam int OV_DB1_US = 50;
  localparam int OV_DB2_US = 80;
  localparam int OV_DB3_US = 125;
  localparam logic [CW-1:0] UV_DB0_CYC = CW'(UV_DB0_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] UV_DB1_CYC = CW'(UV_DB1_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] UV_DB2_CYC = CW'(UV_DB2_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] UV_DB3_CYC = CW'(UV_DB3_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] OV_DB0_CYC = CW'(OV_DB0_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] OV_DB1_DEF = CW'(OV_DB1_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] OV_DB2_DEF = CW'(OV_DB2_US * CLK_HZ / 1_000_000);
  localparam logic [CW-1:0] OV_DB3_DEF = CW'(OV_DB3_US * CLK_HZ / 1_000_000);

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ENABLE = 8'h04;
  localparam logic [7:0] A_KEY = 8'h08;
  localparam logic [7:0] A_UVLVL = 8'h0c;
  localparam logic [7:0] A_OVLVL = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_EVENT = 8'h18;
  localparam logic [7:0] A_MASK = 8'h1c;

  localparam int CTL_UVDB = 0;
  localparam int CTL_OVDB = 2;
  localparam int CTL_SEC = 4;
  localparam int EV_UV = 0;
  localparam int EV_OV = 16;

  localparam logic [1:0] UV_DB_RST = 2'b10;
  localparam logic [1:0] OV_DB_RST = 2'b00;
  localparam logic SEC_RST = 1'b0;
  localparam logic [NCH-1:0] EN_RST = 11'h7ff;
  localparam logic [31:0] SEC_KEY = 32'h0000_00a5;

  typedef struct packed {
    logic [NCH-1:0] ov;
    logic [NCH-1:0] uv;
  } vm_pair_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vm_req_s;

  typedef enum logic {VM_LOCKED = 1'b0, VM_ARMED = 1'b1} vm_lock_e;
endpackage : vm_pkg

// [hdl/vm_monitor.sv]
/*
  Digital supervision of eleven regulator monitors: settings, debounce, status and events.
  Assumes comparator trips, regulator on and in-regulation flags are synchronous to mclk.
*/
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Eleven channels, seven switchers then four linears, each with UV and OV.
// - UV level code 00..11 selects 95, 93, 91, 89 percent of nominal.
// - OV level code 00..11 selects 105, 107, 109, 111 percent of nominal.
// - One shared UV debounce code selects 5, 15, 25 or 40 us.
// - Reset loads the UV debounce code with 10 (25 us).
// - One shared OV debounce code selects 25, 50, 80 or 125 us.
// - Reset loads the OV debounce code with 00, the shortest.
// - Each regulator has an enable bit; 1 supervises, 0 switches its monitor off.
// - All enable bits come out of reset as 1.
// - With secure mode on, enable bits change only through the key sequence.
// - After a regulator turns on, detection waits until it is in regulation.
// - A disabled monitor holds its UV and OV status at 0.
// - Debounce timers run on the monitor clock, counts derived from its rate.

module vm_chan #(
  parameter int W = 14
) (
  input wire logic mclk, // Monitor clock
  input wire logic arst_n, // Async reset, active low
  input wire logic cmp, // Comparator trip
  input wire logic en, // Monitor enabled
  input wire logic mask, // Detection suppressed
  input wire logic [W-1:0] lim, // Debounce length in cycles
  output logic stat_q, // Debounced status
  output logic hit // Status about to set
);
  logic [W-1:0] cnt_q;
  logic act;

  assign act = en && !mask && cmp;
  // Compare with >= so that shortening the interval mid-count cannot wrap the counter
  assign hit = act && !stat_q && (cnt_q >= lim);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      stat_q <= 1'b0;
    end else if (!act) begin
      cnt_q <= '0;
      stat_q <= 1'b0;
    end else if (hit) begin
      stat_q <= 1'b1;
    end else if (!stat_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  a_off_clears: assert property (@(posedge mclk) disable iff (!arst_n)
    !en |=> !stat_q) else $error("status held while monitor off");
  a_glitch_restart: assert property (@(posedge mclk) disable iff (!arst_n)
    !cmp |=> (cnt_q == '0) && !stat_q) else $error("short trip did not restart count");
  a_mask_blocks: assert property (@(posedge mclk) disable iff (!arst_n)
    mask |=> !stat_q) else $error("status set during ramp mask");
  a_set_after_run: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(stat_q) |-> $past(cmp) && ($past(cnt_q) >= $past(lim)))
    else $error("status set before debounce ran out");
endmodule : vm_chan

module vm_monitor #(
  parameter logic [vm_pkg::CW-1:0] OV_DB1_CYC = vm_pkg::OV_DB1_DEF, // OV 50 us count
  parameter logic [vm_pkg::CW-1:0] OV_DB2_CYC = vm_pkg::OV_DB2_DEF, // OV 80 us count
  parameter logic [vm_pkg::CW-1:0] OV_DB3_CYC = vm_pkg::OV_DB3_DEF // OV 125 us count
) (
  input wire logic mclk, // Monitor clock
  input wire logic arst_n, // Async reset, active low
  input wire vm_pkg::vm_req_s req, // Register request
  output logic [31:0] rdata_q, // Read data, cycle after read
  input wire vm_pkg::vm_pair_s cmp_in, // Comparator trips
  input wire logic [vm_pkg::NCH-1:0] reg_on, // Regulator switched on
  input wire logic [vm_pkg::NCH-1:0] reg_in_reg, // Regulator in regulation
  output logic [2*vm_pkg::NSW-1:0] switcher_undervolt_level_sel_q, // UV level codes
  output logic [2*vm_pkg::NLIN-1:0] linear_undervolt_level_sel_q, // UV level codes
  output logic [2*vm_pkg::NSW-1:0] switcher_overvolt_level_sel_q, // OV level codes
  output logic [2*vm_pkg::NLIN-1:0] linear_overvolt_level_sel_q, // OV level codes
  output logic [vm_pkg::NCH-1:0] mon_active_q, // Comparator enables
  output wire vm_pkg::vm_pair_s status_q, // Debounced status
  output logic irq_q // Masked event interrupt
);
  import vm_pkg::*;

  logic [1:0] undervolt_debounce_sel_q;
  logic [1:0] overvolt_debounce_sel_q;
  logic secure_en_q;
  logic [NCH-1:0] monitor_enable_q;
  vm_lock_e lock_q;
  vm_pair_s evt_q;
  vm_pair_s irq_mask_q;
  logic [NCH-1:0] reg_on_q;
  logic [NCH-1:0] ramp_q;
  logic [NCH-1:0] masked;
  logic [NCH-1:0] en_wdata;
  logic [CW-1:0] uv_lim;
  logic [CW-1:0] ov_lim;
  logic [31:0] ctl_word;
  logic en_ok;
  vm_pair_s wr_pair;
  wire vm_pair_s hit;

  function automatic logic [31:0] pair_to_word(vm_pair_s p);
    pair_to_word = 32'h0;
    pair_to_word[EV_UV +: NCH] = p.uv;
    pair_to_word[EV_OV +: NCH] = p.ov;
  endfunction : pair_to_word

  assign en_wdata = req.wdata[NCH-1:0];
  assign wr_pair = {req.wdata[EV_OV +: NCH], req.wdata[EV_UV +: NCH]};
  assign en_ok = !secure_en_q || (lock_q == VM_ARMED);
  // Off regulators are masked too, otherwise they would trip UV at once
  assign masked = ramp_q | ~reg_on_q;

  always_comb begin
    ctl_word = 32'h0;
    ctl_word[CTL_UVDB +: 2] = undervolt_debounce_sel_q;
    ctl_word[CTL_OVDB +: 2] = overvolt_debounce_sel_q;
    ctl_word[CTL_SEC] = secure_en_q;
  end

  always_comb begin
    case (undervolt_debounce_sel_q)
      2'b00: uv_lim = UV_DB0_CYC;
      2'b01: uv_lim = UV_DB1_CYC;
      2'b10: uv_lim = UV_DB2_CYC;
      default: uv_lim = UV_DB3_CYC;
    endcase
  end

  always_comb begin
    case (overvolt_debounce_sel_q)
      2'b00: ov_lim = OV_DB0_CYC;
      2'b01: ov_lim = OV_DB1_CYC;
      2'b10: ov_lim = OV_DB2_CYC;
      default: ov_lim = OV_DB3_CYC;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      undervolt_debounce_sel_q <= UV_DB_RST;
      overvolt_debounce_sel_q <= OV_DB_RST;
      secure_en_q <= SEC_RST;
    end else if (req.wr && req.addr == A_CTRL) begin
      undervolt_debounce_sel_q <= req.wdata[CTL_UVDB +: 2];
      overvolt_debounce_sel_q <= req.wdata[CTL_OVDB +: 2];
      secure_en_q <= req.wdata[CTL_SEC];
    end
  end

  a_uv_db_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (req.wr && req.addr == A_CTRL)
    |=> undervolt_debounce_sel_q == $past(req.wdata[CTL_UVDB +: 2]))
    else $error("UV debounce code write not taken");
  a_ov_db_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (req.wr && req.addr == A_CTRL)
    |=> overvolt_debounce_sel_q == $past(req.wdata[CTL_OVDB +: 2]))
    else $error("OV debounce code write not taken");

  // The key must be the write just before the enable write; any other write disarms
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= VM_LOCKED;
    end else if (req.wr) begin
      lock_q <= (req.addr == A_KEY && req.wdata == SEC_KEY) ? VM_ARMED : VM_LOCKED;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      monitor_enable_q <= EN_RST;
    end else if (req.wr && req.addr == A_ENABLE && en_ok) begin
      monitor_enable_q <= en_wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      switcher_undervolt_level_sel_q <= '0;
      linear_undervolt_level_sel_q <= '0;
      switcher_overvolt_level_sel_q <= '0;
      linear_overvolt_level_sel_q <= '0;
    end else if (req.wr && req.addr == A_UVLVL) begin
      {linear_undervolt_level_sel_q, switcher_undervolt_level_sel_q} <= req.wdata[2*NCH-1:0];
    end else if (req.wr && req.addr == A_OVLVL) begin
      {linear_overvolt_level_sel_q, switcher_overvolt_level_sel_q} <= req.wdata[2*NCH-1:0];
    end
  end

  a_uv_level_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (req.wr && req.addr == A_UVLVL) |=> $past(req.wdata[2*NCH-1:0])
    == {linear_undervolt_level_sel_q, switcher_undervolt_level_sel_q})
    else $error("UV level write not taken");
  a_ov_level_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (req.wr && req.addr == A_OVLVL) |=> $past(req.wdata[2*NCH-1:0])
    == {linear_overvolt_level_sel_q, switcher_overvolt_level_sel_q})
    else $error("OV level write not taken");

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_on_q <= '0;
      ramp_q <= '0;
      mon_active_q <= '0;
    end else begin
      reg_on_q <= reg_on;
      // A regulator already on at reset release counts as just switched on
      ramp_q <= (ramp_q | (reg_on & ~reg_on_q)) & ~reg_in_reg;
      mon_active_q <= monitor_enable_q & ~masked;
    end
  end

  a_ramp_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    (ramp_q != '0) |=> (mon_active_q & $past(ramp_q)) == '0)
    else $error("comparator enabled during ramp");

  // Debounce timers share the monitor clock; counts come from its rate
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    vm_chan #(.W(CW)) u_uv (
      .mclk(mclk),
      .arst_n(arst_n),
      .cmp(cmp_in.uv[i]),
      .en(monitor_enable_q[i]),
      .mask(masked[i]),
      .lim(uv_lim),
      .stat_q(status_q.uv[i]),
      .hit(hit.uv[i])
    );
    vm_chan #(.W(CW)) u_ov (
      .mclk(mclk),
      .arst_n(arst_n),
      .cmp(cmp_in.ov[i]),
      .en(monitor_enable_q[i]),
      .mask(masked[i]),
      .lim(ov_lim),
      .stat_q(status_q.ov[i]),
      .hit(hit.ov[i])
    );
  end

  // Write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_q <= '0;
    end else if (req.wr && req.addr == A_EVENT) begin
      evt_q <= (evt_q & ~wr_pair) | hit;
    end else begin
      evt_q <= evt_q | hit;
    end
  end

  a_off_no_event: assert property (@(posedge mclk) disable iff (!arst_n)
    ((hit.uv | hit.ov) & ~monitor_enable_q) == '0)
    else $error("event raised by disabled monitor");

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_q <= '0;
    end else if (req.wr && req.addr == A_MASK) begin
      irq_mask_q <= wr_pair;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_q & irq_mask_q);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0;
    end else if (!req.rd) begin
      rdata_q <= 32'h0;
    end else begin
      case (req.addr)
        A_CTRL: rdata_q <= ctl_word;
        A_ENABLE: rdata_q <= {{(32-NCH){1'b0}}, monitor_enable_q};
        A_UVLVL: rdata_q <= {10'h0, linear_undervolt_level_sel_q, switcher_undervolt_level_sel_q};
        A_OVLVL: rdata_q <= {10'h0, linear_overvolt_level_sel_q, switcher_overvolt_level_sel_q};
        A_STATUS: rdata_q <= pair_to_word(status_q);
        A_EVENT: rdata_q <= pair_to_word(evt_q);
        A_MASK: rdata_q <= pair_to_word(irq_mask_q);
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  a_secure_block: assert property (@(posedge mclk) disable iff (!arst_n)
    (secure_en_q && lock_q == VM_LOCKED && req.wr && req.addr == A_ENABLE)
    |=> $stable(monitor_enable_q)) else $error("plain write changed enables in secure mode");
  a_plain_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (!secure_en_q && req.wr && req.addr == A_ENABLE) |=> monitor_enable_q == $past(en_wdata))
    else $error("enable write not taken");
  a_uv_db_map: assert property (@(posedge mclk) disable iff (!arst_n)
    (undervolt_debounce_sel_q == 2'b10) |-> (uv_lim == UV_DB2_CYC))
    else $error("UV debounce code 10 not 25 us");
  a_ov_db_map: assert property (@(posedge mclk) disable iff (!arst_n)
    (overvolt_debounce_sel_q == 2'b00) |-> (ov_lim == OV_DB0_CYC))
    else $error("OV debounce code 00 not 25 us");
  a_event_latch: assert property (@(posedge mclk) disable iff (!arst_n)
    (hit != '0) |=> ((evt_q & $past(hit)) == $past(hit))) else $error("status set lost its event");
  a_irq_raise: assert property (@(posedge mclk) disable iff (!arst_n)
    ((evt_q & irq_mask_q) != '0) |=> irq_q) else $error("unmasked event without interrupt");
  a_irq_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    ((evt_q & irq_mask_q) == '0) |=> !irq_q) else $error("interrupt without unmasked event");
  a_read_status: assert property (@(posedge mclk) disable iff (!arst_n)
    (req.rd && req.addr == A_STATUS) |=> rdata_q == pair_to_word($past(status_q)))
    else $error("status read mismatch");
endmodule : vm_monitor

// [tb/vm_cmp_model.sv]
/*
  Behavioural comparators on the eleven regulator outputs.
  Assumes the bench sets one output level, in percent of nominal, for the selected channels.
*/
`timescale 1ns/1ps
module vm_cmp_model (
  input wire logic [2*vm_pkg::NSW-1:0] sw_uv, // Switcher UV level codes
  input wire logic [2*vm_pkg::NLIN-1:0] ln_uv, // Linear UV level codes
  input wire logic [2*vm_pkg::NSW-1:0] sw_ov, // Switcher OV level codes
  input wire logic [2*vm_pkg::NLIN-1:0] ln_ov, // Linear OV level codes
  input wire logic [7:0] pct, // Output level in percent of nominal
  input wire logic [vm_pkg::NCH-1:0] sel, // Channels at pct, others at 100
  output vm_pkg::vm_pair_s cmp_out // Trips toward the monitor
);
  import vm_pkg::*;
  logic [2*NCH-1:0] uv_c;
  logic [2*NCH-1:0] ov_c;
  assign uv_c = {ln_uv, sw_uv};
  assign ov_c = {ln_ov, sw_ov};
  // Never gated by the monitor enables: masking must happen inside the monitor
  always_comb begin
    logic [7:0] v;
    v = 8'h00;
    cmp_out = '0;
    for (int i = 0; i < NCH; i++) begin
      v = sel[i] ? pct : 8'h64;
      cmp_out.uv[i] = v < 8'(UV_PCT0 - 2 * uv_c[2*i +: 2]);
      cmp_out.ov[i] = v > 8'(OV_PCT0 + 2 * ov_c[2*i +: 2]);
    end
  end
endmodule : vm_cmp_model

// [tb/regulator_voltage_monitor_tb.sv]
/*
  Self-checking bench for the voltage monitor through its register port.
  Assumes the comparator model in vm_cmp_model and short OV debounce parameters.
*/
`timescale 1ns/1ps
module regulator_voltage_monitor_tb;
  import vm_pkg::*;
  localparam logic [CW-1:0] OV1 = 14'h001e;
  localparam logic [CW-1:0] OV2 = 14'h0028;
  localparam logic [CW-1:0] OV3 = 14'h0032;
  logic mclk;
  logic arst_n;
  vm_req_s req;
  logic [31:0] rdata_q;
  vm_pair_s cmp_in;
  vm_pair_s status_q;
  logic [NCH-1:0] reg_on;
  logic [NCH-1:0] reg_in_reg;
  logic [NCH-1:0] mon_active_q;
  logic [2*NSW-1:0] sw_uv;
  logic [2*NSW-1:0] sw_ov;
  logic [2*NLIN-1:0] ln_uv;
  logic [2*NLIN-1:0] ln_ov;
  logic irq_q;
  logic [7:0] pct;
  logic [NCH-1:0] sel;
  logic [CW-1:0] lim_t [8];
  int bad_count;
  int checks_done;

  vm_monitor #(.OV_DB1_CYC(OV1), .OV_DB2_CYC(OV2), .OV_DB3_CYC(OV3)) DUT (
    .mclk(mclk), .arst_n(arst_n), .req(req), .rdata_q(rdata_q), .cmp_in(cmp_in),
    .reg_on(reg_on), .reg_in_reg(reg_in_reg),
    .switcher_undervolt_level_sel_q(sw_uv), .linear_undervolt_level_sel_q(ln_uv),
    .switcher_overvolt_level_sel_q(sw_ov), .linear_overvolt_level_sel_q(ln_ov),
    .mon_active_q(mon_active_q), .status_q(status_q), .irq_q(irq_q)
  );
  vm_cmp_model partner (
    .sw_uv(sw_uv), .ln_uv(ln_uv), .sw_ov(sw_ov), .ln_ov(ln_ov),
    .pct(pct), .sel(sel), .cmp_out(cmp_in)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] st();
    return {10'h000, status_q};
  endfunction : st

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic at(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : at

  // Each access leaves one idle cycle so no strobe is assigned twice in a step
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    at(1);
    req <= '0;
    at(1);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    at(1);
    req <= '0;
    chk(rdata_q, e);
    at(1);
    chk(rdata_q, 32'h0);
  endtask : bus_rd

  task automatic finish_test;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    arst_n = 1'b0;
    req = '0;
    reg_on = '1;
    reg_in_reg = '1;
    pct = 8'h64;
    sel = '0;
    bad_count = 0;
    checks_done = 0;
    lim_t = '{UV_DB0_CYC, UV_DB1_CYC, UV_DB2_CYC, UV_DB3_CYC, OV_DB0_CYC, OV1, OV2, OV3};
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    at(1);
    bus_rd(A_CTRL, 32'h2);
    bus_rd(A_ENABLE, 32'h7ff);
    bus_rd(A_STATUS, 32'h0);
    bus_rd(A_KEY, 32'h0);
    bus_rd(8'h20, 32'h0);
    bus_wr(A_CTRL, 32'h4);
    // Channel 0 for UV, channel 8 (second linear) for OV
    for (int c = 0; c < 4; c++) begin
      bus_wr(A_UVLVL, 32'(c));
      bus_wr(A_OVLVL, 32'(c) << 16);
      bus_rd(A_UVLVL, 32'(c));
      bus_rd(A_OVLVL, 32'(c) << 16);
      chk(32'({ln_uv, sw_uv}), 32'(c));
      chk(32'({ln_ov, sw_ov}), 32'(c) << 16);
      sel <= 11'h001;
      pct <= 8'h5f - 8'(2 * c);
      at(520);
      chk(st(), 32'h0);
      pct <= 8'h5e - 8'(2 * c);
      at(520);
      chk(st(), 32'h1);
      sel <= 11'h100;
      pct <= 8'h69 + 8'(2 * c);
      at(40);
      chk(st(), 32'h0);
      pct <= 8'h6a + 8'(2 * c);
      at(40);
      chk(st(), 32'h1 << 19);
      pct <= 8'h64;
      at(3);
    end
    // Every debounce code, with a short excursion first that must not count
    for (int k = 0; k < 8; k++) begin
      bus_wr(A_CTRL, k < 4 ? 32'(k) : 32'(k - 4) << 2);
      sel <= 11'h002;
      pct <= k < 4 ? 8'h50 : 8'h78;
      at(int'(lim_t[k]) - 5);
      pct <= 8'h64;
      at(2);
      pct <= k < 4 ? 8'h50 : 8'h78;
      at(int'(lim_t[k]) - 1);
      chk(st(), 32'h0);
      at(5);
      chk(st(), k < 4 ? 32'h2 : 32'h2 << 11);
      pct <= 8'h64;
      at(3);
    end
    bus_wr(A_CTRL, 32'h4);
    sel <= 11'h7ff;
    pct <= 8'h50;
    at(520);
    bus_rd(A_STATUS, 32'h7ff);
    bus_wr(A_ENABLE, 32'h7fd);
    at(2);
    chk(st(), 32'h7fd);
    chk(32'(mon_active_q), 32'h7fd);
    bus_wr(A_ENABLE, 32'h7ff);
    at(520);
    chk(st(), 32'h7ff);
    pct <= 8'h64;
    at(3);
    bus_wr(A_EVENT, 32'hffff_ffff);
    bus_wr(A_MASK, 32'h2);
    bus_rd(A_EVENT, 32'h0);
    bus_rd(A_MASK, 32'h2);
    chk(32'(irq_q), 32'h0);
    sel <= 11'h002;
    pct <= 8'h50;
    at(510);
    chk(32'(irq_q), 32'h1);
    pct <= 8'h64;
    at(3);
    bus_rd(A_EVENT, 32'h2);
    bus_wr(A_EVENT, 32'h2);
    at(2);
    chk(32'(irq_q), 32'h0);
    bus_wr(A_CTRL, 32'h14);
    bus_wr(A_ENABLE, 32'h0);
    bus_rd(A_ENABLE, 32'h7ff);
    bus_wr(A_KEY, SEC_KEY);
    bus_wr(A_ENABLE, 32'h7fe);
    bus_rd(A_ENABLE, 32'h7fe);
    bus_wr(A_KEY, SEC_KEY);
    bus_wr(A_CTRL, 32'h14);
    bus_wr(A_ENABLE, 32'h0);
    bus_rd(A_ENABLE, 32'h7fe);
    bus_wr(A_KEY, SEC_KEY);
    bus_wr(A_ENABLE, 32'h7ff);
    bus_wr(A_CTRL, 32'h4);
    // Regulator 2 off, then ramping, then in regulation
    reg_on <= 11'h7fb;
    sel <= 11'h004;
    pct <= 8'h50;
    at(600);
    chk(st(), 32'h0);
    reg_on <= '1;
    reg_in_reg <= 11'h7fb;
    at(600);
    chk(st(), 32'h0);
    reg_in_reg <= '1;
    at(520);
    chk(st(), 32'h4);
    // Reset again mid-run: settings and enables must return to their reset values
    bus_wr(A_ENABLE, 32'h0);
    arst_n <= 1'b0;
    at(2);
    arst_n <= 1'b1;
    at(1);
    bus_rd(A_CTRL, 32'h2);
    bus_rd(A_ENABLE, 32'h7ff);
    finish_test();
  end
endmodule : regulator_voltage_monitor_tb
